// [hdl/lpmc_top.sv]
// Low-power mode controller: voltage range, sleep, stop and standby sequencing
// Summary of operation
// - Three voltage ranges cap the processor clock at 32, 16 and 4.2 MHz.
// - Top range: one wait state above 16 MHz, none at or below.
// - Middle range: one wait state from 8 MHz; lowest range never.
// - Sleep halts only the processor clock; any peripheral interrupt wakes it.
// - Low-power run: multispeed oscillator at 131 kHz or less, regulator low-power.
// - Low-power sleep is sleep with the regulator in low-power state.
// - Waking from low-power sleep returns to run; regulator full power unless low-power run is still requested.
// - Stop with clock: core clocks and fast oscillators off, slow kept, retained.
// - Stop without clock: core clocks off, only watchdog, wake and display clocks kept, contents retained, regulator low-power.
// - In stop, a wake-capable peripheral may turn on the fast internal oscillator.
// - Any external event line wakes stop within 3.5 us.
// - Comparator events wake stop only while the internal reference is on.
// - Standby turns the regulator off and loses the core domain.
// - Standby with clock exits within 60 us on reset, watchdog, pins, clock events.
// - Standby without clock exits within 60 us on reset pin or wake pin.
// - Stop and standby leave the watchdog and its source running, and the clock and its source only in their with-clock forms.
`timescale 1ns/1ps
`default_nettype none
module lpmc_top #(
    parameter int EVENT_LINES = 16
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_sleep_req,
    input wire lpmc_pkg::lpmc_mode_t i_mode_sel,
    input wire logic i_lp_run_req,
    input wire logic i_periph_irq,
    input wire lpmc_pkg::lpmc_range_t i_range,
    input wire logic [15:0] i_cpu_freq_khz,
    input wire lpmc_pkg::lpmc_osc_t i_osc_req,
    input wire logic i_independent_watchdog_running,
    input wire logic i_display_enable,
    input wire logic i_fast_osc_wake_req,
    input wire logic i_vref_enabled,
    input wire logic [EVENT_LINES-1:0] i_external_event_line,
    input wire lpmc_pkg::lpmc_wake_src_t i_wake_src,
    input wire logic [lpmc_pkg::WAKE_PINS-1:0] i_wake_pin,
    input wire logic i_external_reset_pin_n,
    input wire logic i_independent_watchdog_reset,
    output logic o_cpu_clk_en,
    output logic o_core_clk_en,
    output lpmc_pkg::lpmc_osc_t o_osc_en,
    output lpmc_pkg::lpmc_reg_t o_regulator,
    output logic o_core_power_on,
    output logic o_retain,
    output logic o_msi_low_speed,
    output logic o_display_clk_en,
    output logic o_core_reset,
    output logic o_wake_done,
    output logic o_wait_state,
    output logic o_freq_over_limit,
    output logic o_freq_step_error,
    output lpmc_pkg::lpmc_state_t o_state
);
    localparam int SYNC_W = EVENT_LINES + $bits(lpmc_pkg::lpmc_wake_src_t) + lpmc_pkg::WAKE_PINS + 2;

    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] sync_out;
    logic [EVENT_LINES-1:0] ev_s;
    lpmc_pkg::lpmc_wake_src_t src_s;
    logic [lpmc_pkg::WAKE_PINS-1:0] pin_s;
    logic rst_pin_s;
    logic wdg_s;

    assign sync_in = {i_external_event_line, i_wake_src, i_wake_pin, ~i_external_reset_pin_n,
                      i_independent_watchdog_reset};
    assign {ev_s, src_s, pin_s, rst_pin_s, wdg_s} = sync_out;

    lpmc_sync #(.WIDTH(SYNC_W)) u_sync (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_async(sync_in),
        .o_sync(sync_out)
    );

    lpmc_wait_calc u_wait (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_range(i_range),
        .i_freq_khz(i_cpu_freq_khz),
        .o_wait_state(o_wait_state),
        .o_over_limit(o_freq_over_limit)
    );

    // Wake qualification
    lpmc_pkg::lpmc_state_t state_q, state_d;
    logic keep_rtc_q, keep_rtc_d;
    logic [lpmc_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [lpmc_pkg::CNT_W-1:0] sb_wait_q, sb_wait_d;
    logic [lpmc_pkg::WAKE_PINS-1:0] pin_prev_q, pin_prev_d;
    logic pin_rise;
    logic rtc_ev;
    logic stop_wake;
    logic standby_wake;

    always_comb begin
        pin_prev_d = pin_s;
        pin_rise = |(pin_s & ~pin_prev_q);
        rtc_ev = src_s.rtc_alarm | src_s.rtc_tamper | src_s.rtc_stamp | src_s.rtc_wake;
        stop_wake = (|ev_s) | src_s.voltage_detector_out | src_s.serial_wake | src_s.usb_wake
                    | src_s.low_power_serial_wake | src_s.low_power_timer_wake
                    | (keep_rtc_q & rtc_ev)
                    | (i_vref_enabled & (src_s.comp1 | src_s.comp2));
        standby_wake = rst_pin_s | pin_rise
                       | (keep_rtc_q & (wdg_s | rtc_ev));
    end

    // Mode sequencer
    always_comb begin
        state_d = state_q;
        keep_rtc_d = keep_rtc_q;
        cnt_d = cnt_q;
        sb_wait_d = o_wake_done ? '0 : ((sb_wait_q != '0 && sb_wait_q != '1) ? sb_wait_q + 1'b1 : sb_wait_q);
        case (state_q)
            lpmc_pkg::LPMC_ST_RUN: begin
                if (i_sleep_req) begin
                    keep_rtc_d = i_mode_sel.keep_rtc;
                    case (i_mode_sel.sel)
                        lpmc_pkg::LPMC_SEL_SLEEP:
                            state_d = i_lp_run_req ? lpmc_pkg::LPMC_ST_LP_SLEEP : lpmc_pkg::LPMC_ST_SLEEP;
                        lpmc_pkg::LPMC_SEL_STOP: state_d = lpmc_pkg::LPMC_ST_STOP;
                        lpmc_pkg::LPMC_SEL_STANDBY: state_d = lpmc_pkg::LPMC_ST_STANDBY;
                        default: state_d = lpmc_pkg::LPMC_ST_RUN;
                    endcase
                end
            end
            lpmc_pkg::LPMC_ST_SLEEP, lpmc_pkg::LPMC_ST_LP_SLEEP: begin
                if (i_periph_irq) begin
                    state_d = lpmc_pkg::LPMC_ST_RUN;
                end
            end
            lpmc_pkg::LPMC_ST_STOP: begin
                if (stop_wake) begin
                    state_d = lpmc_pkg::LPMC_ST_RESUME;
                    cnt_d = lpmc_pkg::CNT_W'(lpmc_pkg::CLOCK_RESTART_CYCLES - 1);
                end
            end
            lpmc_pkg::LPMC_ST_STANDBY: begin
                if (standby_wake) begin
                    state_d = lpmc_pkg::LPMC_ST_POWER_UP;
                    cnt_d = lpmc_pkg::CNT_W'(lpmc_pkg::POWER_UP_CYCLES - 1);
                    sb_wait_d = lpmc_pkg::CNT_W'(1);
                end
            end
            lpmc_pkg::LPMC_ST_RESUME, lpmc_pkg::LPMC_ST_POWER_UP: begin
                if (cnt_q == '0) begin
                    state_d = lpmc_pkg::LPMC_ST_RUN;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: state_d = lpmc_pkg::LPMC_ST_RUN;
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_q <= lpmc_pkg::LPMC_ST_RUN;
            keep_rtc_q <= 1'b0;
            cnt_q <= '0;
            sb_wait_q <= '0;
            pin_prev_q <= '0;
        end else begin
            state_q <= state_d;
            keep_rtc_q <= keep_rtc_d;
            cnt_q <= cnt_d;
            sb_wait_q <= sb_wait_d;
            pin_prev_q <= pin_prev_d;
        end
    end

    // Power, clock and oscillator controls, registered from the next state
    logic cpu_d, core_d, pwr_d, ret_d, msi_low_d, disp_d, crst_d, done_d;
    lpmc_pkg::lpmc_osc_t osc_d, slow_keep;
    lpmc_pkg::lpmc_reg_t reg_d;
    logic cpu_q, core_q, pwr_q, ret_q, msi_low_q, disp_q, crst_q, done_q;
    lpmc_pkg::lpmc_osc_t osc_q;
    lpmc_pkg::lpmc_reg_t reg_q;
    lpmc_pkg::lpmc_state_t state_out_q;

    always_comb begin
        slow_keep = '0;
        slow_keep.slow_external_osc = keep_rtc_d & i_osc_req.slow_external_osc;
        slow_keep.slow_internal_osc = i_osc_req.slow_internal_osc
                                      & (keep_rtc_d | i_independent_watchdog_running);
        cpu_d = 1'b0;
        core_d = 1'b1;
        pwr_d = 1'b1;
        ret_d = 1'b1;
        msi_low_d = 1'b0;
        disp_d = i_display_enable;
        crst_d = 1'b0;
        osc_d = i_osc_req;
        reg_d = lpmc_pkg::LPMC_REG_MAIN;
        done_d = (state_d == lpmc_pkg::LPMC_ST_RUN) && (state_q != lpmc_pkg::LPMC_ST_RUN);
        case (state_d)
            lpmc_pkg::LPMC_ST_RUN, lpmc_pkg::LPMC_ST_LP_SLEEP: begin
                cpu_d = (state_d == lpmc_pkg::LPMC_ST_RUN);
                if (i_lp_run_req || state_d == lpmc_pkg::LPMC_ST_LP_SLEEP) begin
                    reg_d = lpmc_pkg::LPMC_REG_LOW_POWER;
                    msi_low_d = 1'b1;
                    osc_d.pll = 1'b0;
                    osc_d.fast_external_osc = 1'b0;
                    osc_d.fast_internal_osc = 1'b0;
                    osc_d.multispeed_internal_osc = 1'b1;
                end
            end
            lpmc_pkg::LPMC_ST_SLEEP: begin
                cpu_d = 1'b0;
            end
            lpmc_pkg::LPMC_ST_STOP: begin
                core_d = 1'b0;
                reg_d = lpmc_pkg::LPMC_REG_LOW_POWER;
                osc_d = slow_keep;
                osc_d.fast_internal_osc = i_fast_osc_wake_req;
            end
            lpmc_pkg::LPMC_ST_STANDBY: begin
                core_d = 1'b0;
                pwr_d = 1'b0;
                ret_d = 1'b0;
                crst_d = 1'b1;
                disp_d = 1'b0;
                reg_d = lpmc_pkg::LPMC_REG_OFF;
                osc_d = slow_keep;
            end
            lpmc_pkg::LPMC_ST_RESUME: begin
                core_d = 1'b0;
                osc_d.multispeed_internal_osc = 1'b1;
            end
            lpmc_pkg::LPMC_ST_POWER_UP: begin
                core_d = 1'b0;
                ret_d = 1'b0;
                crst_d = 1'b1;
                disp_d = 1'b0;
                osc_d.multispeed_internal_osc = 1'b1;
            end
            default: begin
                cpu_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            cpu_q <= 1'b1;
            core_q <= 1'b1;
            pwr_q <= 1'b1;
            ret_q <= 1'b1;
            msi_low_q <= 1'b0;
            disp_q <= 1'b0;
            crst_q <= 1'b0;
            done_q <= 1'b0;
            osc_q <= '0;
            reg_q <= lpmc_pkg::LPMC_REG_MAIN;
            state_out_q <= lpmc_pkg::LPMC_ST_RUN;
        end else begin
            cpu_q <= cpu_d;
            core_q <= core_d;
            pwr_q <= pwr_d;
            ret_q <= ret_d;
            msi_low_q <= msi_low_d;
            disp_q <= disp_d;
            crst_q <= crst_d;
            done_q <= done_d;
            osc_q <= osc_d;
            reg_q <= reg_d;
            state_out_q <= state_d;
        end
    end

    // Watch on software clock steps
    logic [15:0] freq_prev_q, freq_prev_d;
    logic [7:0] gap_q, gap_d;
    logic step_err_q, step_err_d;
    logic freq_change;

    always_comb begin
        freq_change = (i_cpu_freq_khz != freq_prev_q);
        freq_prev_d = i_cpu_freq_khz;
        gap_d = (gap_q != '0) ? gap_q - 1'b1 : gap_q;
        step_err_d = 1'b0;
        if (freq_change) begin
            gap_d = 8'(lpmc_pkg::FREQ_GAP_CYCLES);
            step_err_d = (gap_q != '0)
                         || ({2'h0, freq_prev_q} >= 18'(i_cpu_freq_khz * lpmc_pkg::FREQ_STEP_RATIO));
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            freq_prev_q <= '0;
            gap_q <= '0;
            step_err_q <= 1'b0;
        end else begin
            freq_prev_q <= freq_prev_d;
            gap_q <= gap_d;
            step_err_q <= step_err_d;
        end
    end

    assign o_cpu_clk_en = cpu_q;
    assign o_core_clk_en = core_q;
    assign o_osc_en = osc_q;
    assign o_regulator = reg_q;
    assign o_core_power_on = pwr_q;
    assign o_retain = ret_q;
    assign o_msi_low_speed = msi_low_q;
    assign o_display_clk_en = disp_q;
    assign o_core_reset = crst_q;
    assign o_wake_done = done_q;
    assign o_freq_step_error = step_err_q;
    assign o_state = state_out_q;

    // Checks
    localparam int STOP_MAX = 87;
    localparam int STANDBY_MAX = 1500;

    a_sleep_cpu_only: assert property (@(posedge i_clock) disable iff (i_rst)
        (o_state == lpmc_pkg::LPMC_ST_SLEEP) |-> (!o_cpu_clk_en && o_core_clk_en))
        else $error("sleep must halt only the processor clock");
    a_sleep_irq_wake: assert property (@(posedge i_clock) disable iff (i_rst)
        (state_q == lpmc_pkg::LPMC_ST_SLEEP && i_periph_irq) |=> (o_cpu_clk_en && o_wake_done))
        else $error("sleep not left on interrupt");
    a_lp_run_regulator: assert property (@(posedge i_clock) disable iff (i_rst)
        (state_d == lpmc_pkg::LPMC_ST_RUN && i_lp_run_req)
        |=> (o_regulator == lpmc_pkg::LPMC_REG_LOW_POWER && o_msi_low_speed && !o_osc_en.pll))
        else $error("low-power run settings wrong");
    a_lp_sleep_exit: assert property (@(posedge i_clock) disable iff (i_rst)
        (state_q == lpmc_pkg::LPMC_ST_LP_SLEEP && i_periph_irq && !i_lp_run_req)
        |=> (o_state == lpmc_pkg::LPMC_ST_RUN && o_regulator == lpmc_pkg::LPMC_REG_MAIN))
        else $error("low-power sleep exit left regulator low");
    a_stop_clocks_off: assert property (@(posedge i_clock) disable iff (i_rst)
        (o_state == lpmc_pkg::LPMC_ST_STOP)
        |-> (!o_core_clk_en && !o_osc_en.pll && !o_osc_en.multispeed_internal_osc
             && !o_osc_en.fast_external_osc && o_retain && o_regulator == lpmc_pkg::LPMC_REG_LOW_POWER))
        else $error("stop left a fast clock running");
    a_stop_wake_time: assert property (@(posedge i_clock) disable iff (i_rst)
        (state_q == lpmc_pkg::LPMC_ST_STOP && stop_wake) |-> ##[1:STOP_MAX] o_wake_done)
        else $error("stop wake exceeded 3.5 us");
    a_comp_needs_vref: assert property (@(posedge i_clock) disable iff (i_rst)
        (state_q == lpmc_pkg::LPMC_ST_STOP && !i_vref_enabled && !(|ev_s)
         && (src_s & ~11'h300) == '0) |=> (state_q == lpmc_pkg::LPMC_ST_STOP))
        else $error("comparator woke stop without reference");
    a_standby_off: assert property (@(posedge i_clock) disable iff (i_rst)
        (o_state == lpmc_pkg::LPMC_ST_STANDBY)
        |-> (o_regulator == lpmc_pkg::LPMC_REG_OFF && !o_core_power_on && !o_retain && o_core_reset))
        else $error("standby left core domain powered");
    a_standby_exit_time: assert property (@(posedge i_clock) disable iff (i_rst)
        sb_wait_q <= lpmc_pkg::CNT_W'(STANDBY_MAX))
        else $error("standby exit exceeded 60 us");
    a_standby_norc_wake: assert property (@(posedge i_clock) disable iff (i_rst)
        (state_q == lpmc_pkg::LPMC_ST_STANDBY && !keep_rtc_q && !rst_pin_s && !pin_rise)
        |=> (state_q == lpmc_pkg::LPMC_ST_STANDBY))
        else $error("standby without clock left on a wrong source");
    a_freq_gap_flag: assert property (@(posedge i_clock) disable iff (i_rst)
        (freq_change && gap_q != '0) |=> o_freq_step_error)
        else $error("close clock changes not flagged");
endmodule
`default_nettype wire

// [hdl/lpmc_pkg.sv]
// Shared types and constants of the low-power mode controller
package lpmc_pkg;
    localparam int CLK_PERIOD_NS = 40;
    // Wake and restart timing, in their own unit and in cycles
    localparam int STOP_EXIT_MAX_NS = 3500;
    localparam int STOP_EXIT_CYCLES = STOP_EXIT_MAX_NS / CLK_PERIOD_NS;
    localparam int STANDBY_EXIT_MAX_NS = 60000;
    localparam int STANDBY_EXIT_CYCLES = STANDBY_EXIT_MAX_NS / CLK_PERIOD_NS;
    localparam int CLOCK_RESTART_NS = 1000;
    localparam int CLOCK_RESTART_CYCLES = (CLOCK_RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWER_UP_NS = 50000;
    localparam int POWER_UP_CYCLES = (POWER_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FREQ_GAP_NS = 5000;
    localparam int FREQ_GAP_CYCLES = (FREQ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 11;
    // Frequency limits in kHz
    localparam int FREQ_W = 16;
    localparam logic [15:0] RANGE1_MAX_KHZ = 16'h7d00;
    localparam logic [15:0] RANGE2_MAX_KHZ = 16'h3e80;
    localparam logic [15:0] RANGE3_MAX_KHZ = 16'h1068;
    localparam logic [15:0] RANGE1_WS_ABOVE_KHZ = 16'h3e80;
    localparam logic [15:0] RANGE2_WS_FROM_KHZ = 16'h1f40;
    localparam logic [15:0] LP_RUN_MAX_KHZ = 16'h0083;
    localparam logic [2:0] FREQ_STEP_RATIO = 3'h4;
    localparam int WAKE_PINS = 3;

    typedef enum logic [1:0] {LPMC_RANGE_1 = 2'h1, LPMC_RANGE_2 = 2'h2, LPMC_RANGE_3 = 2'h3} lpmc_range_t;
    typedef enum logic [1:0] {LPMC_SEL_SLEEP, LPMC_SEL_STOP, LPMC_SEL_STANDBY} lpmc_sel_t;
    typedef enum logic [1:0] {LPMC_REG_MAIN, LPMC_REG_LOW_POWER, LPMC_REG_OFF} lpmc_reg_t;
    typedef enum logic [2:0] {
        LPMC_ST_RUN, LPMC_ST_SLEEP, LPMC_ST_LP_SLEEP, LPMC_ST_STOP,
        LPMC_ST_STANDBY, LPMC_ST_RESUME, LPMC_ST_POWER_UP
    } lpmc_state_t;

    typedef struct packed {
        lpmc_sel_t sel;
        logic keep_rtc;
    } lpmc_mode_t;

    typedef struct packed {
        logic pll;
        logic multispeed_internal_osc;
        logic fast_external_osc;
        logic fast_internal_osc;
        logic slow_internal_osc;
        logic slow_external_osc;
    } lpmc_osc_t;

    typedef struct packed {
        logic voltage_detector_out;
        logic comp1;
        logic comp2;
        logic serial_wake;
        logic usb_wake;
        logic low_power_serial_wake;
        logic low_power_timer_wake;
        logic rtc_alarm;
        logic rtc_tamper;
        logic rtc_stamp;
        logic rtc_wake;
    } lpmc_wake_src_t;
endpackage

// [hdl/lpmc_sync.sv]
// Two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module lpmc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_comb begin
                meta_d[g] = i_async[g];
                sync_d[g] = meta_q[g];
            end
        end
    endgenerate

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign o_sync = sync_q;
endmodule
`default_nettype wire

// [hdl/lpmc_wait_calc.sv]
// Flash wait states and frequency ceiling per voltage range
`timescale 1ns/1ps
`default_nettype none
module lpmc_wait_calc (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire lpmc_pkg::lpmc_range_t i_range,
    input wire logic [15:0] i_freq_khz,
    output logic o_wait_state,
    output logic o_over_limit
);
    logic ws_d;
    logic ws_q;
    logic over_d;
    logic over_q;

    always_comb begin
        ws_d = 1'b0;
        over_d = 1'b0;
        case (i_range)
            lpmc_pkg::LPMC_RANGE_1: begin
                ws_d = (i_freq_khz > lpmc_pkg::RANGE1_WS_ABOVE_KHZ);
                over_d = (i_freq_khz > lpmc_pkg::RANGE1_MAX_KHZ);
            end
            lpmc_pkg::LPMC_RANGE_2: begin
                ws_d = (i_freq_khz >= lpmc_pkg::RANGE2_WS_FROM_KHZ);
                over_d = (i_freq_khz > lpmc_pkg::RANGE2_MAX_KHZ);
            end
            lpmc_pkg::LPMC_RANGE_3: begin
                ws_d = 1'b0;
                over_d = (i_freq_khz > lpmc_pkg::RANGE3_MAX_KHZ);
            end
            default: begin
                ws_d = 1'b1;
                over_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            ws_q <= 1'b0;
            over_q <= 1'b0;
        end else begin
            ws_q <= ws_d;
            over_q <= over_d;
        end
    end

    assign o_wait_state = ws_q;
    assign o_over_limit = over_q;

    a_ws_range3_zero: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_range == lpmc_pkg::LPMC_RANGE_3) |=> !o_wait_state)
        else $error("wait state set in lowest range");
    a_ws_range1_fast: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_range == lpmc_pkg::LPMC_RANGE_1 && i_freq_khz > lpmc_pkg::RANGE1_WS_ABOVE_KHZ) |=> o_wait_state)
        else $error("missing wait state above 16 MHz in top range");
endmodule
`default_nettype wire

// [sim/lpmc_core_model.sv]
// Processor core model: sleep requests and paced clock steps
`timescale 1ns/1ps
`default_nettype none
module lpmc_core_model (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_go,
    input wire lpmc_pkg::lpmc_mode_t i_mode,
    input wire logic [15:0] i_freq_tgt,
    input wire logic i_unpaced,
    output logic o_sleep_req,
    output lpmc_pkg::lpmc_mode_t o_mode_sel,
    output logic [15:0] o_freq_khz
);
    int gap;
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_sleep_req <= 1'b0;
            o_mode_sel <= '0;
            o_freq_khz <= 16'h0fa0;
            gap <= 0;
        end else begin
            o_sleep_req <= i_go;
            o_mode_sel <= i_mode;
            gap <= gap + 1;
            // Unpaced jump breaks both step limits on purpose
            if ((gap > 130 || i_unpaced) && o_freq_khz != i_freq_tgt) begin
                o_freq_khz <= (o_freq_khz < {i_freq_tgt, 2'h0} || i_unpaced) ? i_freq_tgt
                              : (o_freq_khz >> 2) + 16'h1;
                gap <= 0;
            end
        end
    end
endmodule
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench of the low-power mode controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic go = 1'b0, lp_run = 1'b0, irq = 1'b0, vref = 1'b0, fwake = 1'b0, unpaced = 1'b0, rst_n = 1'b1;
    lpmc_pkg::lpmc_mode_t mode = '0;
    lpmc_pkg::lpmc_range_t range = lpmc_pkg::LPMC_RANGE_1;
    lpmc_pkg::lpmc_wake_src_t src = '0;
    logic [15:0] tgt = 16'h0fa0, ext = '0;
    logic [2:0] pin = '0;
    logic [15:0] freq;
    lpmc_pkg::lpmc_mode_t msel;
    logic sreq, cpu_en, core_en, pwr, ret, msi_lo, disp, core_rst, done, ws, over, step_err;
    lpmc_pkg::lpmc_osc_t osc;
    lpmc_pkg::lpmc_reg_t regu;
    lpmc_pkg::lpmc_state_t st;
    int num_errors = 0, cmp_count = 0, cyc = 0;

    lpmc_core_model u_core (.i_clock(i_clock), .i_rst(i_rst), .i_go(go), .i_mode(mode), .i_freq_tgt(tgt),
        .i_unpaced(unpaced),
        .o_sleep_req(sreq), .o_mode_sel(msel), .o_freq_khz(freq));
    lpmc_top u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_sleep_req(sreq), .i_mode_sel(msel),
        .i_lp_run_req(lp_run), .i_periph_irq(irq), .i_range(range), .i_cpu_freq_khz(freq),
        .i_osc_req(6'h3f), .i_independent_watchdog_running(1'b1), .i_display_enable(1'b1),
        .i_fast_osc_wake_req(fwake), .i_vref_enabled(vref), .i_external_event_line(ext), .i_wake_src(src),
        .i_wake_pin(pin), .i_external_reset_pin_n(rst_n), .i_independent_watchdog_reset(1'b0),
        .o_cpu_clk_en(cpu_en), .o_core_clk_en(core_en), .o_osc_en(osc), .o_regulator(regu),
        .o_core_power_on(pwr), .o_retain(ret), .o_msi_low_speed(msi_lo), .o_display_clk_en(disp),
        .o_core_reset(core_rst), .o_wake_done(done), .o_wait_state(ws), .o_freq_over_limit(over),
        .o_freq_step_error(step_err), .o_state(st));

    initial begin
        forever #20 i_clock = ~i_clock;
    end

    task automatic finish_test;
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic enter(input logic [2:0] m);
        @(posedge i_clock);
        go <= 1'b1;
        mode <= m;
        @(posedge i_clock);
        go <= 1'b0;
        repeat (3) @(negedge i_clock);
    endtask

    // Waits for the completion pulse, bounded by lim cycles
    task automatic wake(input int lim);
        for (int n = 0; n < lim && done !== 1'b1; n++) @(negedge i_clock);
        chk({done, st}, {1'b1, lpmc_pkg::LPMC_ST_RUN});
        @(posedge i_clock);
        irq <= 1'b0;
        src <= '0;
        ext <= '0;
        pin <= '0;
        vref <= 1'b0;
        fwake <= 1'b0;
        rst_n <= 1'b1;
    endtask

    task automatic t_freq;
        logic [15:0] f[9] = '{16'h3e80, 16'h7d00, 16'h3e80, 16'h3e81, 16'h1f40, 16'h1f3f, 16'h1069, 16'h1068,
                              16'h03e8};
        logic [1:0] r[9] = '{2'h1, 2'h1, 2'h2, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h3};
        logic [2:0] e[9] = '{3'h0, 3'h4, 3'h4, 3'h4, 3'h4, 3'h0, 3'h2, 3'h0, 3'h1};
        for (int i = 0; i < 9; i++) begin
            @(posedge i_clock);
            tgt <= f[i];
            range <= lpmc_pkg::lpmc_range_t'(r[i]);
            unpaced <= (i == 8);
            for (int n = 0; n < 300 && freq !== f[i]; n++) @(negedge i_clock);
            @(negedge i_clock);
            chk({ws, over, step_err}, e[i]);
        end
    endtask

    task automatic t_sleep;
        enter(3'h0);
        chk({st, cpu_en, core_en}, {lpmc_pkg::LPMC_ST_SLEEP, 2'b01});
        @(posedge i_clock);
        irq <= 1'b1;
        wake(4);
        enter(3'h6);
        chk(st, lpmc_pkg::LPMC_ST_RUN);
    endtask

    task automatic t_lp;
        @(posedge i_clock);
        lp_run <= 1'b1;
        repeat (3) @(negedge i_clock);
        chk({msi_lo, regu}, 3'h5);
        enter(3'h0);
        chk({st, regu}, {lpmc_pkg::LPMC_ST_LP_SLEEP, lpmc_pkg::LPMC_REG_LOW_POWER});
        @(posedge i_clock);
        lp_run <= 1'b0;
        irq <= 1'b1;
        wake(4);
        chk(regu, lpmc_pkg::LPMC_REG_MAIN);
    endtask

    task automatic t_stop_rtc;
        enter(3'h3);
        chk({st, osc, regu, ret, core_en, disp}, {lpmc_pkg::LPMC_ST_STOP, 6'h03, 2'h1, 3'b101});
        @(posedge i_clock);
        src <= 11'h200;
        repeat (100) @(negedge i_clock);
        chk(st, lpmc_pkg::LPMC_ST_STOP);
        @(posedge i_clock);
        vref <= 1'b1;
        wake(88);
    endtask

    task automatic t_stop_nortc;
        @(posedge i_clock);
        fwake <= 1'b1;
        src <= 11'h001;
        enter(3'h2);
        repeat (100) @(negedge i_clock);
        chk({st, osc, regu, ret}, {lpmc_pkg::LPMC_ST_STOP, 6'h06, 2'h1, 1'b1});
        @(posedge i_clock);
        ext <= 16'h0008;
        wake(88);
    endtask

    task automatic t_standby;
        enter(3'h5);
        chk({st, regu, pwr, ret, core_rst}, {lpmc_pkg::LPMC_ST_STANDBY, 2'h2, 3'b001});
        @(posedge i_clock);
        src <= 11'h001;
        wake(1500);
        @(posedge i_clock);
        src <= 11'h008;
        enter(3'h4);
        repeat (100) @(negedge i_clock);
        chk(st, lpmc_pkg::LPMC_ST_STANDBY);
        @(posedge i_clock);
        pin <= 3'h4;
        wake(1500);
        enter(3'h4);
        @(posedge i_clock);
        rst_n <= 1'b0;
        wake(1500);
    endtask

    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            finish_test();
        end
    end

    initial begin
        repeat (16) @(posedge i_clock);
        i_rst <= 1'b0;
        repeat (2) @(negedge i_clock);
        t_freq();
        t_sleep();
        t_lp();
        t_stop_rtc();
        t_stop_nortc();
        t_standby();
        finish_test();
    end
endmodule
`default_nettype wire
